// [verilog/ftf_consts.svh]
`ifndef FTF_CONSTS_SVH
`define FTF_CONSTS_SVH
`define FTF_OFS_TEMP_CFG      8'h09
`define FTF_OFS_FLAGS_PRI     8'h0a
`define FTF_OFS_FLAGS_SEC     8'h0b
`define FTF_BIT_TORCH_POL     6
`define FTF_BIT_OPEN_EN       5
`define FTF_BIT_SHORT_EN      4
`define FTF_POS_THRESH        1
`define FTF_BIT_PIN_SEL       0
`define FTF_RST_TEMP_CFG      8'h08
`define FTF_MASK_TEMP_CFG     8'h7f
`define FTF_MASK_FLAGS_SEC    8'h1f
`define FTF_TIMEOUT_STD_MS_12 250
`define FTF_TIMEOUT_STD_MS_13 300
`define FTF_TIMEOUT_STD_MS_14 350
`define FTF_TIMEOUT_STD_MS_15 400
`define FTF_TIMEOUT_EXT_MS_12 1000
`define FTF_TIMEOUT_EXT_MS_13 1200
`define FTF_TIMEOUT_EXT_MS_14 1400
`define FTF_TIMEOUT_EXT_MS_15 1600
`define FTF_THRESH_BASE_MV    200
`define FTF_THRESH_STEP_MV    100
`endif

// [verilog/ftf_pkg.sv]
package ftf_pkg;
  typedef struct packed {
    logic       torchActiveLow;
    logic       openFaultEn;
    logic       shortFaultEn;
    logic [2:0] threshCode;
    logic       pinIsThermistor;
  } ftf_cfg_t;

  typedef struct packed {
    logic rfSync;
    logic outputShort;
    logic ledOneShort;
    logic ledTwoShort;
    logic currentLimit;
    logic thermalShutdown;
    logic undervoltageLockout;
    logic flashTimeout;
  } ftf_evt_pri_t;

  typedef struct packed {
    logic thermistorShort;
    logic thermistorOpen;
    logic inputVoltageFlashMonitor;
    logic outputOvervoltage;
    logic tempTrip;
  } ftf_evt_sec_t;
endpackage

// [verilog/ftf_sticky_flags.sv]
`timescale 1ns/1ps
// Sticky event bits cleared by a read; a new event in the read cycle survives.
module ftf_sticky_flags #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] events,
  input  wire logic         readClr,
  output logic      [W-1:0] flags
);
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  always_comb
  begin
    flags_d = readClr ? events : (flags_q | events); // [R10]
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  assign flags = flags_q;
endmodule

// [verilog/ftf_reg_bank.sv]
`timescale 1ns/1ps
`include "ftf_consts.svh"
// Summary of operation
// R1 - Time-out codes 12..15 give 250..400 ms, or 1000..1600 ms on extended part.
// R2 - Config bit 6 sets torch polarity: 0 active high with pulldown, 1 active low; reset holds the pulldown off although bit 6 resets to 0.
// R3 - Torch polarity change is ignored while torch, flash or IR mode runs.
// R4 - Host disables the device before changing polarity, then re-enables.
// R5 - Bits 5 and 4 enable thermistor open and short fault reporting.
// R6 - Threshold code 0..7 maps 0.2 V to 0.9 V in 0.1 V steps, default 0.6 V.
// R7 - Config bit 0 selects shared pin: 0 torch enable, 1 thermistor input.
// R8 - Primary flags at 0x0a: rf sync, output short, led shorts, limit, tsd, undervoltage_lockout, timeout.
// R9 - Secondary flags at 0x0b: thermistor short/open, flash monitor, overvoltage, temp trip.
// R10 - Flags stick until the host reads them; reserved bits read zero.
module ftf_reg_bank #(
  parameter bit EXT_TIMEOUT = 1'b0
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  output logic      [7:0]           regRdata,
  input  wire logic                 deviceActive,
  input  wire logic [3:0]           timeoutCode,
  input  wire ftf_pkg::ftf_evt_pri_t evtPri,
  input  wire ftf_pkg::ftf_evt_sec_t evtSec,
  output ftf_pkg::ftf_cfg_t         cfg,
  output logic                      torchPulldownEn,
  output logic [10:0]               timeoutMs,
  output logic [9:0]                threshMv
);
  // Detector lines come from the analog side, so each passes two flip-flops first.
  logic [7:0]        evtPriMeta_q;
  logic [7:0]        evtPriMeta_d;
  logic [7:0]        evtPriSync_q;
  logic [7:0]        evtPriSync_d;
  logic [4:0]        evtSecMeta_q;
  logic [4:0]        evtSecMeta_d;
  logic [4:0]        evtSecSync_q;
  logic [4:0]        evtSecSync_d;

  logic [7:0]        cfg_q;
  logic [7:0]        cfg_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic [10:0]       tmo_q;
  logic [10:0]       tmo_d;
  logic [10:0]       tmoStd;
  logic [10:0]       tmoExt;
  logic [9:0]        thr_q;
  logic [9:0]        thr_d;
  logic              pd_q;
  logic              pd_d;
  logic [7:0]        flagsPri;
  logic [4:0]        flagsSec;
  logic [7:0]        evtPriBits;
  logic [4:0]        evtSecBits;
  logic              rdPri;
  logic              rdSec;

  assign rdPri = regRead && (regAddr == `FTF_OFS_FLAGS_PRI);
  assign rdSec = regRead && (regAddr == `FTF_OFS_FLAGS_SEC);

  always_comb
  begin
    evtPriMeta_d = evtPri;
    evtPriSync_d = evtPriMeta_q;
    evtSecMeta_d = evtSec;
    evtSecSync_d = evtSecMeta_q;
  end

  // Both stages clear in reset so no stale detector level is latched after it.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      evtPriMeta_q <= 8'h00;
      evtPriSync_q <= 8'h00;
      evtSecMeta_q <= 5'h00;
      evtSecSync_q <= 5'h00;
    end
    else
    begin
      evtPriMeta_q <= evtPriMeta_d;
      evtPriSync_q <= evtPriSync_d;
      evtSecMeta_q <= evtSecMeta_d;
      evtSecSync_q <= evtSecSync_d;
    end
  end

  // Primary detectors map one to one onto the register bits.
  always_comb
  begin
    evtPriBits[7] = evtPriSync_q[7]; // [R8]
    evtPriBits[6] = evtPriSync_q[6]; // [R8]
    evtPriBits[5] = evtPriSync_q[5]; // [R8]
    evtPriBits[4] = evtPriSync_q[4]; // [R8]
    evtPriBits[3] = evtPriSync_q[3]; // [R8]
    evtPriBits[2] = evtPriSync_q[2]; // [R8]
    evtPriBits[1] = evtPriSync_q[1]; // [R8]
    evtPriBits[0] = evtPriSync_q[0]; // [R8]
  end

  // Thermistor faults only latch when their enable is set.
  assign evtSecBits = {evtSecSync_q[4] & cfg_q[`FTF_BIT_SHORT_EN],
                       evtSecSync_q[3] & cfg_q[`FTF_BIT_OPEN_EN],
                       evtSecSync_q[2],
                       evtSecSync_q[1],
                       evtSecSync_q[0]}; // [R5] [R9]

  ftf_sticky_flags #(.W(8)) uPri (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .events  (evtPriBits),
    .readClr (rdPri),
    .flags   (flagsPri)
  );

  ftf_sticky_flags #(.W(5)) uSec (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .events  (evtSecBits),
    .readClr (rdSec),
    .flags   (flagsSec)
  );

  always_comb
  begin
    cfg_d = cfg_q;
    if (regWrite && regAddr == `FTF_OFS_TEMP_CFG)
    begin
      cfg_d = regWdata & `FTF_MASK_TEMP_CFG;
      // Polarity is frozen while the device runs, so a stray write cannot glitch the pin.
      if (deviceActive)
        cfg_d[`FTF_BIT_TORCH_POL] = cfg_q[`FTF_BIT_TORCH_POL]; // [R3]
    end
    pd_d = ~cfg_d[`FTF_BIT_TORCH_POL]; // [R2]
  end

  always_comb
  begin
    rdata_d = 8'h00;
    // Read data holds between reads, so a slow serial front end may fetch it late.
    if (regRead)
    begin
      case (regAddr)
        `FTF_OFS_TEMP_CFG:  rdata_d = cfg_q;
        `FTF_OFS_FLAGS_PRI: rdata_d = flagsPri;
        `FTF_OFS_FLAGS_SEC: rdata_d = {3'h0, flagsSec}; // [R10]
        default:            rdata_d = 8'h00;
      endcase
    end
    else
      rdata_d = rdata_q;
  end

  always_comb
  begin
    // Codes below 0xc are decoded elsewhere; here they give zero.
    case (timeoutCode)
      4'hc:    tmoStd = 11'(`FTF_TIMEOUT_STD_MS_12); // [R1]
      4'hd:    tmoStd = 11'(`FTF_TIMEOUT_STD_MS_13); // [R1]
      4'he:    tmoStd = 11'(`FTF_TIMEOUT_STD_MS_14); // [R1]
      4'hf:    tmoStd = 11'(`FTF_TIMEOUT_STD_MS_15); // [R1]
      default: tmoStd = 11'h000;
    endcase
    // The extended part trades flash length for heat; the build picks one table.
    case (timeoutCode)
      4'hc:    tmoExt = 11'(`FTF_TIMEOUT_EXT_MS_12); // [R1]
      4'hd:    tmoExt = 11'(`FTF_TIMEOUT_EXT_MS_13); // [R1]
      4'he:    tmoExt = 11'(`FTF_TIMEOUT_EXT_MS_14); // [R1]
      4'hf:    tmoExt = 11'(`FTF_TIMEOUT_EXT_MS_15); // [R1]
      default: tmoExt = 11'h000;
    endcase
    tmo_d = EXT_TIMEOUT ? tmoExt : tmoStd; // [R1]
  end

  always_comb
  begin
    case (cfg_q[`FTF_POS_THRESH +: 3])
      3'h0:    thr_d = 10'(`FTF_THRESH_BASE_MV); // [R6]
      3'h1:    thr_d = 10'(`FTF_THRESH_BASE_MV + 1 * `FTF_THRESH_STEP_MV); // [R6]
      3'h2:    thr_d = 10'(`FTF_THRESH_BASE_MV + 2 * `FTF_THRESH_STEP_MV); // [R6]
      3'h3:    thr_d = 10'(`FTF_THRESH_BASE_MV + 3 * `FTF_THRESH_STEP_MV); // [R6]
      3'h4:    thr_d = 10'(`FTF_THRESH_BASE_MV + 4 * `FTF_THRESH_STEP_MV); // [R6]
      3'h5:    thr_d = 10'(`FTF_THRESH_BASE_MV + 5 * `FTF_THRESH_STEP_MV); // [R6]
      3'h6:    thr_d = 10'(`FTF_THRESH_BASE_MV + 6 * `FTF_THRESH_STEP_MV); // [R6]
      3'h7:    thr_d = 10'(`FTF_THRESH_BASE_MV + 7 * `FTF_THRESH_STEP_MV); // [R6]
      default: thr_d = 10'(`FTF_THRESH_BASE_MV);
    endcase
  end

  // Pulldown is stored beside the polarity bit; reset loads it off, so the two agree only from the first clock after reset.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cfg_q   <= `FTF_RST_TEMP_CFG;
      rdata_q <= 8'h00;
      tmo_q   <= 11'h000;
      thr_q   <= 10'h000;
      pd_q    <= 1'b0;
    end
    else
    begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
      tmo_q   <= tmo_d;
      thr_q   <= thr_d;
      pd_q    <= pd_d;
    end
  end

  assign regRdata        = rdata_q;
  assign cfg             = cfg_q[6:0]; // [R2] [R5] [R7]
  assign torchPulldownEn = pd_q;
  assign timeoutMs       = tmo_q;
  assign threshMv        = thr_q;
endmodule

// [verification/ftf_host.sv]
`timescale 1ns/1ps
module ftf_host (
  input  wire logic  clk_sys,
  output logic       regWrite,
  output logic       regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  initial {regWrite, regRead, regAddr, regWdata} = 18'h0;
  // Address and data go to the inverse and strobes to zero when released, so a stale value is never read as live.
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clk_sys);
    {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
    @(negedge clk_sys);
    {regWrite, regRead, regAddr, regWdata} = {2'h0, ~a, ~d};
  endtask
endmodule

// [verification/ftf_reg_bank_assertions.sv]
`timescale 1ns/1ps
module ftf_chk #(
  parameter bit EXT_TIMEOUT = 1'b0
) (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [7:0]        regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic [7:0]        regRdata,
  input wire logic              deviceActive,
  input wire logic [3:0]        timeoutCode,
  input wire ftf_pkg::ftf_cfg_t cfg,
  input wire logic              torchPulldownEn,
  input wire logic [10:0]       timeoutMs,
  input wire logic [9:0]        threshMv
);
  localparam logic [10:0] Base = EXT_TIMEOUT ? 11'h3e8 : 11'h0fa;
  localparam logic [10:0] Step = EXT_TIMEOUT ? 11'h0c8 : 11'h032;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_pull; $past(nrst) |-> torchPulldownEn == !cfg[6]; endproperty
  a_pull: assert property (p_pull) else $error("pulldown");
  property p_pol; regWrite && regAddr == 8'h09 |=>
    cfg[6] == ($past(deviceActive) ? $past(cfg[6]) : $past(regWdata[6])); endproperty
  a_pol: assert property (p_pol) else $error("polarity");
  property p_wr; regWrite && regAddr == 8'h09 |=> cfg[5:0] == $past(regWdata[5:0]); endproperty
  a_wr: assert property (p_wr) else $error("config write");
  property p_mv; $past(nrst) |-> threshMv == 10'(10'h0c8 + 10'h064 * $past(cfg[3:1])); endproperty
  a_mv: assert property (p_mv) else $error("threshold");
  property p_ms; $past(nrst) |-> timeoutMs == ($past(timeoutCode[3:2]) == 2'h3 ?
    11'(Base + Step * $past(timeoutCode[1:0])) : 11'h000); endproperty
  a_ms: assert property (p_ms) else $error("timeout");
  property p_rc; regRead && regAddr == 8'h09 |=> regRdata == {1'b0, $past(cfg)}; endproperty
  a_rc: assert property (p_rc) else $error("config read");
  property p_rsv; regRead && regAddr == 8'h0b |=> regRdata[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_un; regRead && !(regAddr inside {[8'h09:8'h0b]}) |=> regRdata == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped");
endmodule
bind ftf_reg_bank ftf_chk #(.EXT_TIMEOUT(EXT_TIMEOUT)) u_chk (.*);

// [verification/flash_temp_config_fault_flags_bench.sv]
`timescale 1ns/1ps
module flash_temp_config_fault_flags_bench;
  logic                  clk_sys = 1'b0;
  logic                  nrst = 1'b0;
  logic                  deviceActive = 1'b0;
  logic [3:0]            timeoutCode = 4'h0;
  ftf_pkg::ftf_evt_pri_t evtPri = '0;
  ftf_pkg::ftf_evt_sec_t evtSec = '0;
  logic                  regWrite, regRead, torchPulldownEn;
  logic [7:0]            regAddr, regWdata, regRdata;
  ftf_pkg::ftf_cfg_t     cfg;
  logic [10:0]           timeoutMs;
  logic [9:0]            threshMv;
  int                    errors = 0;
  int                    n_checks = 0;
  // Row: config byte, time-out code, expected ms, expected mV.
  logic [32:0] rows [4] = '{{8'h00, 4'hb, 11'h000, 10'h0c8}, {8'h4e, 4'hc, 11'h0fa, 10'h384},
    {8'h32, 4'hd, 11'h12c, 10'h12c}, {8'h7f, 4'hf, 11'h190, 10'h384}};
  always #50 clk_sys = ~clk_sys;
  ftf_host host_u (.*);
  ftf_reg_bank dut_u (.*);
  task automatic chk(input logic [10:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    host_u.acc(1'b0, a, 8'h00);
    chk(11'(regRdata), 11'(e));
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // The tests need about 70 cycles; 2000 leaves ample margin.
  initial
  begin
    #200000;
    errors++;
    final_report;
  end
  initial
  begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    rd(8'h09, 8'h08);
    chk(11'(threshMv), 11'h258);
    foreach (rows[i])
    begin
      timeoutCode = rows[i][24:21];
      host_u.acc(1'b1, 8'h09, rows[i][32:25]);
      rd(8'h09, rows[i][32:25] & 8'h7f);
      chk(timeoutMs, rows[i][20:10]);
      chk(11'(threshMv), 11'(rows[i][9:0]));
      chk(11'(torchPulldownEn), 11'(!rows[i][31]));
    end
    $display("table done");
    deviceActive = 1'b1;
    host_u.acc(1'b1, 8'h09, 8'h08);
    rd(8'h09, 8'h48);
    deviceActive = 1'b0;
    host_u.acc(1'b1, 8'h09, 8'h08);
    rd(8'h09, 8'h08);
    $display("polarity done");
    evtPri = 8'hff;
    evtSec = 5'h1f;
    @(negedge clk_sys);
    evtPri = '0;
    evtSec = '0;
    repeat (2) @(negedge clk_sys);
    rd(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    evtPri = 8'h01;
    @(negedge clk_sys);
    evtPri = '0;
    rd(8'h0a, 8'h00);
    rd(8'h0a, 8'h01);
    rd(8'h0b, 8'h07);
    host_u.acc(1'b1, 8'h09, 8'h38);
    evtSec = 5'h18;
    @(negedge clk_sys);
    evtSec = '0;
    repeat (2) @(negedge clk_sys);
    rd(8'h0b, 8'h18);
    host_u.acc(1'b1, 8'h0c, 8'h55);
    rd(8'h0c, 8'h00);
    $display("flags done");
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(11'(cfg), 11'h008);
    chk(11'(regRdata), 11'h000);
    nrst = 1'b1;
    rd(8'h09, 8'h08);
    $display("reset done");
    final_report;
  end
endmodule
